// ==== wake_enable_and_smi_status_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wke_cfg.svh"
module wake_enable_and_smi_status_bench;
    import wke_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic         wreq_n, irq, er;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata;
    logic [7:0]   rd, cnt, ia;
    logic [2:0]   smi_n;
    wke_sources_t pins_n;
    int           fails, check_count, cyc;
    wke_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_pins_n(pins_n), .smi_pins_n(smi_n),
        .wake_request_out_n(wreq_n), .irq(irq));
    wke_pm_model pm (.pclk(pclk), .presetn(presetn),
        .wake_request_out_n(wreq_n), .wake_count(cnt));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task end_of_test;
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, e);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_of_test;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pins_n = 16'hffff;
        smi_n = 3'h7;
        {fails, check_count, cyc} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(`WKE_OFF_EN_TWO, 8'h00);
        rc(`WKE_OFF_EN_THREE, 8'h00);
        rc(`WKE_OFF_SMI_STS, 8'h00);
        apb(1'b0, 12'h0fc, 8'h00);
        chk({7'h00, er}, 8'h01);
        apb(1'b1, `WKE_OFF_EN_TWO, 8'hff);
        rc(`WKE_OFF_EN_TWO, 8'hbf);
        apb(1'b1, `WKE_OFF_EN_THREE, 8'ha5);
        rc(`WKE_OFF_EN_THREE, 8'ha5);
        pins_n.group_three[0] <= 1'b0;
        repeat (6) @(posedge pclk);
        chk({7'h00, wreq_n}, 8'h01);
        rc(`WKE_OFF_STS_THREE, 8'h01);
        apb(1'b1, `WKE_OFF_CTRL, 8'h01);
        repeat (2) @(posedge pclk);
        chk({7'h00, wreq_n}, 8'h00);
        apb(1'b1, `WKE_OFF_EN_THREE, 8'h00);
        repeat (2) @(posedge pclk);
        chk({7'h00, wreq_n}, 8'h01);
        rc(`WKE_OFF_STS_THREE, 8'h01);
        apb(1'b1, `WKE_OFF_STS_THREE, 8'h01);
        rc(`WKE_OFF_STS_THREE, 8'h00);
        pins_n.group_two <= 8'h7e;
        repeat (6) @(posedge pclk);
        chk({7'h00, wreq_n}, 8'h00);
        rc(`WKE_OFF_STS_TWO, 8'h81);
        apb(1'b1, `WKE_OFF_STS_TWO, 8'h81);
        repeat (2) @(posedge pclk);
        chk({7'h00, wreq_n}, 8'h01);
        chk(cnt, 8'h02);
        apb(1'b0, `WKE_OFF_IRQ_STS, 8'h00);
        smi_n <= 3'h6;
        repeat (6) @(posedge pclk);
        rc(`WKE_OFF_SMI_STS, 8'h02);
        apb(1'b1, `WKE_OFF_IRQ_MASK, 8'h00);
        @(negedge pclk);
        ia = {7'h00, irq};
        @(posedge pclk);
        apb(1'b1, `WKE_OFF_IRQ_MASK, 8'h03);
        @(negedge pclk);
        chk(ia ^ {7'h00, irq}, 8'h01);
        @(posedge pclk);
        rc(`WKE_OFF_IRQ_STS, 8'h02);
        chk({7'h00, irq}, 8'h00);
        apb(1'b1, `WKE_OFF_SMI_STS, 8'h02);
        rc(`WKE_OFF_SMI_STS, 8'h00);
        smi_n <= 3'h1;
        repeat (6) @(posedge pclk);
        rc(`WKE_OFF_SMI_STS, 8'h0c);
        apb(1'b1, `WKE_OFF_SMI_STS, 8'h0c);
        rc(`WKE_OFF_SMI_STS, 8'h00);
        apb(1'b1, `WKE_OFF_EN_THREE, 8'h5a);
        smi_n  <= 3'h7;
        pins_n <= 16'hffff;
        repeat (6) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(`WKE_OFF_EN_THREE, 8'h00);
        rc(`WKE_OFF_EN_TWO, 8'h00);
        rc(`WKE_OFF_SMI_STS, 8'h00);
        chk({7'h00, wreq_n}, 8'h01);
        end_of_test;
    end
endmodule
`default_nettype wire

// ==== wke_cfg.svh ====
`ifndef WKE_CFG_SVH
`define WKE_CFG_SVH
// Register indices; each register sits on its own word
`define WKE_IDX_STS_TWO   12'h003
`define WKE_IDX_STS_THREE 12'h004
`define WKE_IDX_EN_TWO    12'h006
`define WKE_IDX_EN_THREE  12'h007
`define WKE_IDX_SMI_STS   12'h008
`define WKE_OFF_STS_TWO   (`WKE_IDX_STS_TWO << 2)
`define WKE_OFF_STS_THREE (`WKE_IDX_STS_THREE << 2)
`define WKE_OFF_EN_TWO    (`WKE_IDX_EN_TWO << 2)
`define WKE_OFF_EN_THREE  (`WKE_IDX_EN_THREE << 2)
`define WKE_OFF_SMI_STS   (`WKE_IDX_SMI_STS << 2)
`define WKE_OFF_CTRL      12'h040
`define WKE_OFF_IRQ_STS   12'h044
`define WKE_OFF_IRQ_MASK  12'h048
`define WKE_RST_BYTE      8'h00
`define WKE_EN_TWO_MASK   8'hbf
`define WKE_SMI_MASK      8'h0e
`define WKE_IRQ_WAKE      0
`define WKE_IRQ_SMI       1
`define WKE_IRQ_MASK      2'h3
`endif

// ==== wke_pkg.sv ====
package wke_pkg;
    typedef struct packed {
        logic [7:0] group_two;
        logic [7:0] group_three;
    } wke_sources_t;
    typedef struct packed {
        logic [7:0] rdata;
        logic       hit;
    } wke_read_t;
endpackage

// ==== wke_pm_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module wke_pm_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       wake_request_out_n,
    output logic      [7:0] wake_count
);
    logic prev_n;
    // Counts each new wake request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_n     <= 1'b1;
            wake_count <= 8'h00;
        end else begin
            prev_n <= wake_request_out_n;
            if (prev_n && !wake_request_out_n) begin
                wake_count <= wake_count + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== wke_unit.sv ====
// Behaviour
// - Wake asserts only when enabled, set, master-enabled
// - Disabled sources still record status
// - Group two enable bit map, bit six reserved
// - Group three enable maps pins thirty-37
// - Group three enable survives all but standby reset
// - Standby reset clears enables and status
// - Writing one clears management status bit
// - Management status bits one to three
// - Software reads pending management events
// - Wake status sets regardless of enables
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "wke_cfg.svh"
module wke_unit
    import wke_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire wke_sources_t         wake_pins_n,
    input  wire logic [2:0]           smi_pins_n,
    output logic                      wake_request_out_n,
    output logic                      irq
);
    // Three-stage synchronisers, event on agreed falling level
    wke_sources_t s1, s2, s3;
    logic [2:0]   m1, m2, m3;
    wke_sources_t ev;
    logic [2:0]   smi_ev;
    wke_sources_t lvl, next_lvl;
    logic [2:0]   smi_lvl, next_smi_lvl;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1      <= '1;
            s2      <= '1;
            s3      <= '1;
            lvl     <= '1;
            m1      <= 3'h7;
            m2      <= 3'h7;
            m3      <= 3'h7;
            smi_lvl <= 3'h7;
        end else begin
            s1      <= wake_pins_n;
            s2      <= s1;
            s3      <= s2;
            lvl     <= next_lvl;
            m1      <= smi_pins_n;
            m2      <= m1;
            m3      <= m2;
            smi_lvl <= next_smi_lvl;
        end
    end
    // A level counts only once stages two and three agree
    always_comb begin
        next_lvl     = (s2 & s3) | (lvl & (s2 ^ s3));
        next_smi_lvl = (m2 & m3) | (smi_lvl & (m2 ^ m3));
        ev           = lvl & ~s2 & ~s3;
        smi_ev       = smi_lvl & ~m2 & ~m3;
    end

    logic        wr, rd;
    logic [7:0]  wb;
    always_comb begin
        wr = psel && penable && pwrite;
        rd = psel && penable && !pwrite;
        wb = pwdata[7:0];
    end

    logic [7:0] sts_two, sts_three, en_two, en_three, smi_sts;
    logic       master_en;
    logic [1:0] irq_sts, irq_mask;
    logic [7:0] next_sts_two, next_sts_three, next_en_two, next_en_three;
    logic [7:0] next_smi_sts;
    logic       next_master_en;
    logic [1:0] next_irq_sts, next_irq_mask;
    logic       any_wake, any_smi;
    always_comb begin
        next_sts_two   = sts_two;
        next_sts_three = sts_three;
        next_en_two    = en_two;
        next_en_three  = en_three;
        next_smi_sts   = smi_sts;
        next_master_en = master_en;
        next_irq_mask  = irq_mask;
        next_irq_sts   = irq_sts;
        if (wr) begin
            case (paddr)
                `WKE_OFF_STS_TWO:   next_sts_two   = sts_two & ~wb;
                `WKE_OFF_STS_THREE: next_sts_three = sts_three & ~wb;
                `WKE_OFF_EN_TWO:    next_en_two = wb & `WKE_EN_TWO_MASK;
                `WKE_OFF_EN_THREE:  next_en_three  = wb;
                `WKE_OFF_SMI_STS:   next_smi_sts   = smi_sts & ~wb;
                `WKE_OFF_CTRL:      next_master_en = wb[0];
                `WKE_OFF_IRQ_MASK:  next_irq_mask = wb[1:0] & `WKE_IRQ_MASK;
                default: ;
            endcase
        end
        if (rd && paddr == `WKE_OFF_IRQ_STS) begin
            next_irq_sts = 2'h0;
        end
        // Set beats clear, independent of enables
        next_sts_two   = next_sts_two | (ev.group_two & `WKE_EN_TWO_MASK);
        next_sts_three = next_sts_three | ev.group_three;
        next_smi_sts   = next_smi_sts | ({4'h0, smi_ev, 1'b0} & `WKE_SMI_MASK);
        any_wake = |ev.group_two | |ev.group_three;
        any_smi  = |smi_ev;
        next_irq_sts[`WKE_IRQ_WAKE] = next_irq_sts[`WKE_IRQ_WAKE] | any_wake;
        next_irq_sts[`WKE_IRQ_SMI]  = next_irq_sts[`WKE_IRQ_SMI] | any_smi;
    end
    // Single standby-power reset domain; no other reset reaches these
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_two   <= `WKE_RST_BYTE;
            sts_three <= `WKE_RST_BYTE;
            en_two    <= `WKE_RST_BYTE;
            en_three  <= `WKE_RST_BYTE;
            smi_sts   <= `WKE_RST_BYTE;
            master_en <= 1'b0;
            irq_sts   <= 2'h0;
            irq_mask  <= 2'h0;
        end else begin
            sts_two   <= next_sts_two;
            sts_three <= next_sts_three;
            en_two    <= next_en_two;
            en_three  <= next_en_three;
            smi_sts   <= next_smi_sts;
            master_en <= next_master_en;
            irq_sts   <= next_irq_sts;
            irq_mask  <= next_irq_mask;
        end
    end

    logic next_wake_n;
    always_comb begin
        next_wake_n = !(master_en && |{sts_two & en_two, sts_three & en_three});
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_request_out_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            wake_request_out_n <= next_wake_n;
            irq <= |(next_irq_sts & irq_mask);
        end
    end

    wke_read_t rsel;
    always_comb begin
        rsel.hit = 1'b1;
        case (paddr)
            `WKE_OFF_STS_TWO:   rsel.rdata = sts_two;
            `WKE_OFF_STS_THREE: rsel.rdata = sts_three;
            `WKE_OFF_EN_TWO:    rsel.rdata = en_two;
            `WKE_OFF_EN_THREE:  rsel.rdata = en_three;
            `WKE_OFF_SMI_STS:   rsel.rdata = smi_sts;
            `WKE_OFF_CTRL:      rsel.rdata = {7'h00, master_en};
            `WKE_OFF_IRQ_STS:   rsel.rdata = {6'h00, irq_sts};
            `WKE_OFF_IRQ_MASK:  rsel.rdata = {6'h00, irq_mask};
            default: begin
                rsel.rdata = 8'h00;
                rsel.hit   = 1'b0;
            end
        endcase
        pready  = 1'b1;
        pslverr = psel && penable && !rsel.hit;
        prdata  = {24'h000000, rsel.rdata};
    end

    property p_wake_gate;
        @(posedge pclk) disable iff (!presetn)
        !wake_request_out_n |-> $past(master_en);
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake without master");
    property p_wake_on;
        @(posedge pclk) disable iff (!presetn)
        (master_en && |(sts_two & en_two)) |=> !wake_request_out_n;
    endproperty
    a_wake_on: assert property (p_wake_on) else $error("wake not driven");
    property p_rec;
        @(posedge pclk) disable iff (!presetn)
        ev.group_three[0] |=> sts_three[0];
    endproperty
    a_rec: assert property (p_rec) else $error("event lost");
    property p_rec2;
        @(posedge pclk) disable iff (!presetn)
        ev.group_two[0] |=> sts_two[0];
    endproperty
    a_rec2: assert property (p_rec2) else $error("disabled event lost");
    property p_res;
        @(posedge pclk) disable iff (!presetn)
        !en_two[6];
    endproperty
    a_res: assert property (p_res) else $error("reserved set");
    property p_en3;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `WKE_OFF_EN_THREE) |=> en_three == $past(pwdata[7:0]);
    endproperty
    a_en3: assert property (p_en3) else $error("enable three wrong");
    property p_w1c;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `WKE_OFF_SMI_STS && pwdata[1] && !smi_ev[0])
            |=> !smi_sts[1];
    endproperty
    a_w1c: assert property (p_w1c) else $error("w1c failed");
    property p_smi;
        @(posedge pclk) disable iff (!presetn)
        smi_ev[2] |=> smi_sts[3] ##0 !smi_sts[0] ##0 !smi_sts[4];
    endproperty
    a_smi: assert property (p_smi) else $error("smi map wrong");
    // Event pulses last one cycle so a held pin sets status once
    property p_ev_pulse;
        @(posedge pclk) disable iff (!presetn)
        ev.group_two[7] |=> !ev.group_two[7];
    endproperty
    a_ev_pulse: assert property (p_ev_pulse) else $error("event held");
    property p_smi_pulse;
        @(posedge pclk) disable iff (!presetn)
        smi_ev[0] |=> !smi_ev[0];
    endproperty
    a_smi_pulse: assert property (p_smi_pulse) else $error("smi held");
    property p_no_master;
        @(posedge pclk) disable iff (!presetn)
        !master_en |=> wake_request_out_n;
    endproperty
    a_no_master: assert property (p_no_master) else $error("wake unmastered");
    property p_gated_off;
        @(posedge pclk) disable iff (!presetn)
        !(|{sts_two & en_two, sts_three & en_three}) |=> wake_request_out_n;
    endproperty
    a_gated_off: assert property (p_gated_off) else $error("wake ungated");
    property p_sts3_w1c;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `WKE_OFF_STS_THREE && pwdata[0] && !ev.group_three[0])
            |=> !sts_three[0];
    endproperty
    a_sts3_w1c: assert property (p_sts3_w1c) else $error("status three stuck");
    property p_sts2_w1c;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `WKE_OFF_STS_TWO && pwdata[7] && !ev.group_two[7])
            |=> !sts_two[7];
    endproperty
    a_sts2_w1c: assert property (p_sts2_w1c) else $error("status two stuck");
    property p_smi_set;
        @(posedge pclk) disable iff (!presetn)
        smi_ev[0] |=> smi_sts[1];
    endproperty
    a_smi_set: assert property (p_smi_set) else $error("smi lost");
    property p_smi_rsv;
        @(posedge pclk) disable iff (!presetn)
        !smi_sts[0] && (smi_sts[7:4] == 4'h0);
    endproperty
    a_smi_rsv: assert property (p_smi_rsv) else $error("smi reserved set");
    property p_en2_wr;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `WKE_OFF_EN_TWO)
            |=> en_two == ($past(pwdata[7:0]) & `WKE_EN_TWO_MASK);
    endproperty
    a_en2_wr: assert property (p_en2_wr) else $error("enable two wrong");
    property p_en3_hold;
        @(posedge pclk) disable iff (!presetn)
        !(wr && paddr == `WKE_OFF_EN_THREE) |=> $stable(en_three);
    endproperty
    a_en3_hold: assert property (p_en3_hold) else $error("enable three lost");
    // Event, then status, then wake, while enables stay on
    sequence s_ev_armed;
        ev.group_two[7] && en_two[7] && master_en;
    endsequence
    sequence s_wake_follows;
        sts_two[7] ##1 !wake_request_out_n;
    endsequence
    property p_ev_wake;
        @(posedge pclk) disable iff (!presetn)
        s_ev_armed ##1 (en_two[7] && master_en) |-> s_wake_follows;
    endproperty
    a_ev_wake: assert property (p_ev_wake) else $error("wake chain broken");
    property p_smi_read;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == `WKE_OFF_SMI_STS) |-> prdata[7:0] == smi_sts;
    endproperty
    a_smi_read: assert property (p_smi_read) else $error("smi read wrong");
    property p_irq_smi;
        @(posedge pclk) disable iff (!presetn)
        any_smi |=> irq_sts[`WKE_IRQ_SMI];
    endproperty
    a_irq_smi: assert property (p_irq_smi) else $error("smi irq lost");
endmodule
`default_nettype wire
